// file: include/sbbp_pkg.sv
// constants for the system bus beat and parity signalling block
// How it works
// R1: whoever drives the data bus drives parity_lane_6 so it and data bits 48..55 hold odd ones.
// R2: whoever drives the data bus drives parity_lane_7 so it and data bits 56..63 hold odd ones.
// R3: the data source asserts beat_valid_strobe once for every data beat it moves.
// R4: termination_acknowledge only ends a transfer and is never asserted without the strobe.
// R5: a two-doubleword transfer to a 32-bit port takes four beats, the last with both strobes.
// R6: external_grant_line_3 is asserted when the arbiter hands the bus to the master on line 3.
// R7: an external peripheral asserts dma_request_line_3 or _4 to ask for dma service.
// R8: an external master asserts external_request_line_3 before it can be granted the bus.
package sbbp_pkg;
   localparam int          DATA_W       = 64;
   localparam int          LANE6_LO     = 48;
   localparam int          LANE7_LO     = 56;
   localparam int          LANE_W       = 8;
   localparam int          HALF_W       = 32;
   localparam int          FIFO_DEPTH   = 8;
   localparam int          XFER_WORDS   = 2;
   localparam logic [1:0]  LAST_BEAT_64 = 2'h1;
   localparam logic [1:0]  LAST_BEAT_32 = 2'h3;
   localparam logic [1:0]  BEAT_RST     = 2'h0;
   typedef enum logic {SBBP_IDLE, SBBP_DRIVE} sbbp_state_type;
endpackage

// file: hdl/sbbp_top.sv
// data-phase beat, termination and upper-lane parity logic with outbound fifo
`timescale 1ns/1ps
`default_nettype none

module sbbp_fifo #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 8
) (
   input  wire logic             clock,
   input  wire logic             arst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two >= 2");
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_q;
   logic [AW:0]      rd_q;
   logic             push;
   logic             pop;

   assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
   assign out_valid = wr_q != rd_q;
   assign out_data  = mem[rd_q[AW-1:0]];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule

module sbbp_top #(
   parameter int FIFO_DEPTH = sbbp_pkg::FIFO_DEPTH
) (
   input  wire logic        clock,
   input  wire logic        arst_n,
   // user side: words to send, transfer start
   input  wire logic        wr_valid,
   output logic             wr_ready,
   input  wire logic [63:0] wr_data,
   input  wire logic        xfer_start,
   input  wire logic        port_is_32,
   output logic             xfer_busy,
   output logic             xfer_done,
   // user side: received beats
   output logic             rx_beat,
   output logic             rx_end,
   output logic [63:0]      rx_data,
   output logic [1:0]       rx_parity_err,
   output logic             rx_ack_err,
   // system bus data phase pins
   input  wire logic [63:0] data_in,
   output logic [63:0]      data_out,
   output logic             data_oe,
   input  wire logic        parity_lane_6_in,
   output logic             parity_lane_6_out,
   input  wire logic        parity_lane_7_in,
   output logic             parity_lane_7_out,
   output logic             parity_oe,
   input  wire logic        beat_valid_strobe_in,
   output logic             beat_valid_strobe_out,
   output logic             beat_valid_strobe_oe,
   input  wire logic        termination_acknowledge_in,
   output logic             termination_acknowledge_out,
   output logic             termination_acknowledge_oe,
   // arbitration and dma
   input  wire logic        external_request_line_3,
   input  wire logic        arb_grant_ext3,
   output logic             external_grant_line_3,
   input  wire logic        dma_request_line_3,
   input  wire logic        dma_request_line_4,
   output logic [1:0]       dma_service_req
);
   if (FIFO_DEPTH < 2) $error("fifo depth below two cannot hold a two-word transfer");

   ////////////////////////////////////////////////////////////////////////////
   // outbound fifo
   logic                   fifo_valid;
   logic                   fifo_pop;
   logic [63:0]            fifo_data;

   sbbp_fifo #(.WIDTH(sbbp_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock     (clock),
      .arst_n    (arst_n),
      .in_valid  (wr_valid),
      .in_ready  (wr_ready),
      .in_data   (wr_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // beat sequencer
   sbbp_pkg::sbbp_state_type state_q;
   logic                   port32_q;
   logic [1:0]             beat_q;
   logic [31:0]            hold_q;
   logic                   need_word;
   logic                   fire;
   logic                   last;
   logic [63:0]            beat_data;

   assign need_word = ~port32_q | ~beat_q[0];
   assign fire      = (state_q == sbbp_pkg::SBBP_DRIVE) & (~need_word | fifo_valid);
   assign fifo_pop  = fire & need_word;
   assign last      = beat_q == (port32_q ? sbbp_pkg::LAST_BEAT_32 : sbbp_pkg::LAST_BEAT_64); // R5
   // a 32-bit port carries each doubleword as high half then low half on the upper lanes
   assign beat_data = !port32_q ? fifo_data :
                      need_word ? {fifo_data[63:32], 32'h0} : {hold_q, 32'h0};
   assign xfer_busy = state_q == sbbp_pkg::SBBP_DRIVE;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_q  <= sbbp_pkg::SBBP_IDLE;
         port32_q <= 1'b0;
         beat_q   <= sbbp_pkg::BEAT_RST;
      end else begin
         case (state_q)
            sbbp_pkg::SBBP_IDLE: begin
               if (xfer_start) begin
                  state_q  <= sbbp_pkg::SBBP_DRIVE;
                  port32_q <= port_is_32;
                  beat_q   <= sbbp_pkg::BEAT_RST;
               end
            end
            sbbp_pkg::SBBP_DRIVE: begin
               if (fire) begin
                  beat_q <= beat_q + 2'h1;
                  if (last) begin
                     state_q <= sbbp_pkg::SBBP_IDLE;
                  end
               end
            end
            default: begin
               state_q <= sbbp_pkg::SBBP_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         hold_q <= 32'h0;
      end else if (fifo_pop) begin
         hold_q <= fifo_data[31:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drivers; a stall while the fifo is empty shows as a cycle without strobe
   logic [63:0]            dout_q;
   logic                   p6_q;
   logic                   p7_q;
   logic                   bvs_q;
   logic                   ta_q;
   logic                   oe_q;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         dout_q <= 64'h0;
         p6_q   <= 1'b1;
         p7_q   <= 1'b1;
         bvs_q  <= 1'b0;
         ta_q   <= 1'b0;
         oe_q   <= 1'b0;
      end else begin
         oe_q  <= xfer_busy & ~(fire & last);
         bvs_q <= fire; // R3
         ta_q  <= fire & last; // R4 R5
         if (fire) begin
            dout_q <= beat_data;
            p6_q   <= ~^beat_data[sbbp_pkg::LANE6_LO +: sbbp_pkg::LANE_W]; // R1
            p7_q   <= ~^beat_data[sbbp_pkg::LANE7_LO +: sbbp_pkg::LANE_W]; // R2
         end
      end
   end

   assign data_out                    = dout_q;
   assign parity_lane_6_out           = p6_q;
   assign parity_lane_7_out           = p7_q;
   assign beat_valid_strobe_out       = bvs_q;
   assign termination_acknowledge_out = ta_q;
   assign data_oe                     = oe_q | bvs_q;
   assign parity_oe                   = oe_q | bvs_q;
   assign beat_valid_strobe_oe        = oe_q | bvs_q;
   assign termination_acknowledge_oe  = oe_q | bvs_q;
   assign xfer_done                   = ta_q;

   ////////////////////////////////////////////////////////////////////////////
   // inbound beats from another agent
   logic                   rx_beat_q;
   logic                   rx_end_q;
   logic [63:0]            rx_data_q;
   logic [1:0]             rx_perr_q;
   logic                   rx_aerr_q;
   logic                   listen;

   // our own drive is not checked against itself
   assign listen = ~data_oe;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rx_beat_q <= 1'b0;
         rx_end_q  <= 1'b0;
         rx_data_q <= 64'h0;
         rx_perr_q <= 2'h0;
         rx_aerr_q <= 1'b0;
      end else begin
         rx_beat_q <= listen & beat_valid_strobe_in;
         rx_end_q  <= listen & beat_valid_strobe_in & termination_acknowledge_in;
         rx_aerr_q <= listen & termination_acknowledge_in & ~beat_valid_strobe_in; // R4
         rx_perr_q <= 2'h0;
         if (listen & beat_valid_strobe_in) begin
            rx_data_q    <= data_in;
            rx_perr_q[0] <= ~^{parity_lane_6_in,
                               data_in[sbbp_pkg::LANE6_LO +: sbbp_pkg::LANE_W]}; // R1
            rx_perr_q[1] <= ~^{parity_lane_7_in,
                               data_in[sbbp_pkg::LANE7_LO +: sbbp_pkg::LANE_W]}; // R2
         end
      end
   end

   assign rx_beat       = rx_beat_q;
   assign rx_end        = rx_end_q;
   assign rx_data       = rx_data_q;
   assign rx_parity_err = rx_perr_q;
   assign rx_ack_err    = rx_aerr_q;

   ////////////////////////////////////////////////////////////////////////////
   // grant and dma request capture
   logic                   grant_q;
   logic [1:0]             dreq_q;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         grant_q <= 1'b0;
         dreq_q  <= 2'h0;
      end else begin
         grant_q <= arb_grant_ext3 & external_request_line_3; // R6 R8
         dreq_q  <= {dma_request_line_4, dma_request_line_3}; // R7
      end
   end

   assign external_grant_line_3 = grant_q;
   assign dma_service_req       = dreq_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_lane6_odd: assert property (@(posedge clock) disable iff (!arst_n)
      bvs_q |-> ^{p6_q, dout_q[55:48]}) else $error("lane 6 parity not odd"); // R1
   a_lane7_odd: assert property (@(posedge clock) disable iff (!arst_n)
      bvs_q |-> ^{p7_q, dout_q[63:56]}) else $error("lane 7 parity not odd"); // R2
   a_beat_strobe: assert property (@(posedge clock) disable iff (!arst_n)
      fire |=> bvs_q) else $error("beat moved without strobe"); // R3
   a_ack_needs_strobe: assert property (@(posedge clock) disable iff (!arst_n)
      ta_q |-> bvs_q && !xfer_busy) else $error("ack without strobe or not at end"); // R4
   a_four_beat_end: assert property (@(posedge clock) disable iff (!arst_n)
      (fire && port32_q && beat_q == 2'h0) |=> (!ta_q && bvs_q)) else $error("early end"); // R5
   a_port32_last: assert property (@(posedge clock) disable iff (!arst_n)
      (fire && port32_q && beat_q == 2'h3) |=> ta_q) else $error("no end at beat four"); // R5
   a_port64_last: assert property (@(posedge clock) disable iff (!arst_n)
      (fire && !port32_q && beat_q == 2'h1) |=> ta_q) else $error("no end at beat two"); // R5
   a_grant_cause: assert property (@(posedge clock) disable iff (!arst_n)
      external_grant_line_3 |-> $past(external_request_line_3) && $past(arb_grant_ext3))
      else $error("grant without request and arbiter decision"); // R6
   a_dma_follow: assert property (@(posedge clock) disable iff (!arst_n)
      dma_service_req == $past({dma_request_line_4, dma_request_line_3}))
      else $error("dma request not passed on"); // R7

   c_port32: cover property (@(posedge clock) disable iff (!arst_n) ta_q && port32_q);
   c_port64: cover property (@(posedge clock) disable iff (!arst_n) ta_q && !port32_q);
   c_stall: cover property (@(posedge clock) disable iff (!arst_n) xfer_busy && !fire);
   c_rx_end: cover property (@(posedge clock) disable iff (!arst_n) rx_end);
endmodule

`default_nettype wire

// file: bench/sbbp_agent_model.sv
// far-side bus agent model: records device beats and sends beats of its own
`timescale 1ns/1ps
`default_nettype none
module sbbp_agent_model (
   input  wire logic        clock,
   input  wire logic [63:0] data_out,
   input  wire logic        par6_o,
   input  wire logic        par7_o,
   input  wire logic        strobe_o,
   input  wire logic        strobe_oe,
   input  wire logic        ack_o,
   output logic      [63:0] p_data,
   output logic             p_par6,
   output logic             p_par7,
   output logic             p_strobe,
   output logic             p_ack
);
   logic [66:0] beat_q[$];
   initial begin
      p_data = 64'h0;
      {p_par6, p_par7, p_strobe, p_ack} = 4'h0;
   end
   always @(posedge clock) begin
      if (strobe_oe && strobe_o) begin
         beat_q.push_back({ack_o, par7_o, par6_o, data_out});
      end
   end
   // gap makes the answer slow; bad and no_stb are faults that a scenario asks for
   task automatic send_beat(input logic [63:0] d, input logic last, input logic [1:0] bad,
                            input logic no_stb, input int gap);
      repeat (gap) @(negedge clock);
      @(negedge clock);
      p_data = d;
      p_par6 = ~^d[55:48] ^ bad[0];
      p_par7 = ~^d[63:56] ^ bad[1];
      p_strobe = ~no_stb;
      p_ack = last;
      @(negedge clock);
      // released data and parity lines show the inverse and strobe and ack drop low so stale data never looks valid
      p_data = ~p_data;
      p_par6 = ~p_par6;
      p_par7 = ~p_par7;
      p_strobe = 1'b0;
      p_ack = 1'b0;
   endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// self-checking bench: fifo, transmit beats, receive beats, grant and dma follow
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        clock, arst_n, wr_valid, xfer_start, port_is_32, ext_req, arb_grant, dma3, dma4;
   logic        wr_ready, xfer_busy, xfer_done, rx_beat, rx_end, rx_ack_err, data_oe, grant3;
   logic        par6_o, par7_o, par_oe, strobe_o, strobe_oe, ack_o, ack_oe;
   logic        p_par6, p_par7, p_strobe, p_ack;
   logic [63:0] wr_data, data_out, rx_data, p_data, d;
   logic [1:0]  rx_parity_err, dma_service_req;
   logic [3:0]  prev;
   logic [66:0] exp_q[$];
   logic [63:0] words[$];
   int          error_cnt, samples_checked, cycles, k;

   sbbp_top #(.FIFO_DEPTH(8)) u_sbbp_top (.clock, .arst_n, .wr_valid, .wr_ready, .wr_data,
      .xfer_start, .port_is_32, .xfer_busy, .xfer_done, .rx_beat, .rx_end, .rx_data,
      .rx_parity_err, .rx_ack_err, .data_in(data_oe ? data_out : p_data), .data_out, .data_oe,
      .parity_lane_6_in(par_oe ? par6_o : p_par6), .parity_lane_6_out(par6_o),
      .parity_lane_7_in(par_oe ? par7_o : p_par7), .parity_lane_7_out(par7_o),
      .parity_oe(par_oe), .beat_valid_strobe_in(strobe_oe ? strobe_o : p_strobe),
      .beat_valid_strobe_out(strobe_o), .beat_valid_strobe_oe(strobe_oe),
      .termination_acknowledge_in(ack_oe ? ack_o : p_ack), .termination_acknowledge_out(ack_o),
      .termination_acknowledge_oe(ack_oe), .external_request_line_3(ext_req),
      .arb_grant_ext3(arb_grant), .external_grant_line_3(grant3), .dma_request_line_3(dma3),
      .dma_request_line_4(dma4), .dma_service_req);
   sbbp_agent_model u_sbbp_agent_model (.clock, .data_out, .par6_o, .par7_o, .strobe_o,
      .strobe_oe, .ack_o, .p_data, .p_par6, .p_par7, .p_strobe, .p_ack);

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check_val(input string what, input logic [67:0] e, input logic [67:0] g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   function automatic logic [66:0] mk_beat(input logic [63:0] x, input logic last);
      return {last, ~^x[63:56], ~^x[55:48], x};
   endfunction
   // a second start is offered while busy and must leave the beat count alone
   // late > 0 starts on an empty fifo and feeds both words only after that many idle cycles
   task automatic run_xfer(input logic w32, input int late);
      logic [63:0] w0, w1;
      w0 = words.pop_front();
      w1 = words.pop_front();
      if (w32) begin
         exp_q = {mk_beat({w0[63:32], 32'h0}, 0), mk_beat({w0[31:0], 32'h0}, 0),
                  mk_beat({w1[63:32], 32'h0}, 0), mk_beat({w1[31:0], 32'h0}, 1)};
      end else begin
         exp_q = {mk_beat(w0, 0), mk_beat(w1, 1)};
      end
      xfer_start = 1'b1;
      port_is_32 = w32;
      @(negedge clock);
      check_val("busy", 1, xfer_busy);
      @(negedge clock);
      xfer_start = 1'b0;
      if (late > 0) begin
         repeat (late) @(negedge clock);
         check_val("stall", 3'h6, {xfer_busy, data_oe, strobe_o});
         check_val("stall beats", 0, u_sbbp_agent_model.beat_q.size());
         wr_valid = 1'b1;
         wr_data = w0;
         @(negedge clock);
         wr_data = w1;
         @(negedge clock);
         wr_valid = 1'b0;
      end
      for (int i = 0; i < 20 && xfer_done !== 1'b1; i++) @(negedge clock);
      check_val("done with ack", 7'h7f,
                {xfer_done, ack_o, ack_oe, strobe_o, strobe_oe, data_oe, par_oe});
      @(negedge clock);
      check_val("beats", exp_q.size(), u_sbbp_agent_model.beat_q.size());
      while (exp_q.size() > 0 && u_sbbp_agent_model.beat_q.size() > 0)
         check_val("beat", exp_q.pop_front(), u_sbbp_agent_model.beat_q.pop_front());
      check_val("idle", 0, {xfer_busy, xfer_done, data_oe, par_oe, strobe_oe, ack_oe});
      $display("transfer test done, 32-bit port %0d", w32);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   initial begin
      {arst_n, wr_valid, xfer_start, port_is_32, ext_req, arb_grant, dma3, dma4} = 8'h0;
      wr_data = 64'h0;
      void'($urandom(32'h2ec8));
      repeat (20) @(negedge clock);
      check_val("reset", 7'h70, {wr_ready, par7_o, par6_o, strobe_o, ack_o, data_oe, grant3});
      arst_n = 1'b1;
      @(negedge clock);
      for (int i = 0; i < 12 && wr_ready === 1'b1; i++) begin
         wr_data = {$urandom, $urandom};
         wr_valid = 1'b1;
         words.push_back(wr_data);
         @(negedge clock);
      end
      @(negedge clock);
      wr_valid = 1'b0;
      check_val("fifo fill", 8, words.size());
      $display("fifo fill test done");
      for (k = 0; k < 4; k++) run_xfer(k == 1 || k == 2, 0);
      for (k = 0; k < 2; k++) begin
         words.push_back({$urandom, $urandom});
         words.push_back({$urandom, $urandom});
         run_xfer(k == 0, 3);
      end
      for (k = 0; k < 4; k++) begin
         d = {$urandom, $urandom};
         u_sbbp_agent_model.send_beat(d, k == 3, k[1:0], 1'b0, k);
         check_val("rx", {1'b1, k == 3, k[1:0], d}, {rx_beat, rx_end, rx_parity_err, rx_data});
      end
      u_sbbp_agent_model.send_beat(d, 1'b1, 2'h0, 1'b1, 0);
      check_val("ack alone", 2'h1, {rx_beat, rx_ack_err});
      $display("receive test done");
      for (k = 0; k < 40; k++) begin
         prev = 4'($urandom);
         {ext_req, arb_grant, dma4, dma3} = prev;
         @(negedge clock);
         check_val("grant dma", {prev[3] & prev[2], prev[1:0]}, {grant3, dma_service_req});
      end
      $display("grant and dma test done");
      report_and_stop();
   end
endmodule
`default_nettype wire
